// >>> core/stpc_pkg.sv
// package: constants of the transmit coding and pattern test block
package stpc_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_EN   = 8'h0C;
    localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_W10_BIT  = 3;
    localparam int CTRL_LOOP_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_OVF  = 2;
    localparam int IRQ_UNF  = 3;
    localparam int IRQ_N    = 4;
    // fifo
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_AW    = 2;
    localparam int FIFO_W     = 11;
    // pattern generator and verifier
    localparam int LFSR_W  = 23;
    localparam int ERR_MIN = 3;
    localparam logic [23:0] PER_P7  = 24'h00_007F;
    localparam logic [23:0] PER_P8  = 24'h00_00FF;
    localparam logic [23:0] PER_P10 = 24'h00_03FF;
    localparam logic [23:0] PER_P23 = 24'h7F_FFFF;
    localparam logic [9:0] HF_WORD = 10'h2AA;
    localparam logic [9:0] LF_WORD = 10'h3E0;
    typedef enum logic [2:0] {
        PM_OFF  = 3'b000,
        PM_P7   = 3'b001,
        PM_P8   = 3'b010,
        PM_P10  = 3'b011,
        PM_P23  = 3'b100,
        PM_HF   = 3'b101,
        PM_LF   = 3'b110
    } stpc_mode_t;
endpackage

// >>> core/stpc_top.sv
// transmit coding path with pattern generator and pattern verifier
//
// Behaviour
// [RL1] generator emits 8- or 10-bit words per configured width; LF_WORD stays 10 bits in 8-bit width until the serializer mask
// [RL2] fixed high/low frequency patterns get no verifier, no done/error
// [RL3] loopback routes generated pattern into the receive verifier
// [RL4] done rises after alignment and a full pattern cycle; held until rx reset
// [RL5] after done, an error holds error flag >=3 cycles; clean sequence clears it
// [RL6] tx reset clears the generator, rx reset clears the verifier
// [RL7] fabric presents transmit data synchronous to the transmit clock
// [RL8] channel drives its own transmit interface clock out
// [RL9] fabric write clock may stand in for the fifo write clock
// [RL10] fifo error output high while fifo is full or empty
// [RL11] control select chooses K or D code group, carried through fifo
// [RL12] force disparity uses given value, else running disparity; via fifo
// [RL13] forced value high picks negative, low picks positive disparity
// [RL14] polarity input inverts every word bit; held two cycles by fabric
// [RL15] slip amount 0..9 sets bits slipped before serializer
// [RL16] force idle puts output buffer to electrical idle levels
// [RL17] each random pattern restarts after a full iteration
// [RL18] generator before serializer, verifier after word aligner
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module stpc_top (
    // clock and resets
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        tx_rst,
    input  wire logic        rx_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    // fabric transmit side
    input  wire logic        tx_wr,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_ctrl,
    input  wire logic        tx_force_disp,
    input  wire logic        tx_disp_val,
    input  wire logic        tx_invert,
    input  wire logic [3:0]  tx_slip_amount,
    input  wire logic        force_line_idle,
    output logic             tx_if_clk,
    output logic             fifo_err,
    // encoder stage
    output logic             enc_valid,
    output logic [7:0]       enc_byte,
    output logic             enc_k,
    output logic             enc_force,
    output logic             enc_neg,
    input  wire logic [9:0]  enc_word,
    // serializer and receive side
    output logic [9:0]       ser_word,
    output logic             ser_idle,
    input  wire logic [9:0]  rx_word,
    input  wire logic        rx_aligned,
    output logic             chk_done,
    output logic             chk_err
);
    // =========================================================
    // registers
    localparam int IRQ_N = stpc_pkg::IRQ_N;
    logic [4:0]          ctrl;
    logic [IRQ_N-1:0]    irq_stat;
    logic [IRQ_N-1:0]    irq_en;
    wire  [2:0] mode_raw = ctrl[stpc_pkg::CTRL_MODE_LSB +: 3];
    wire        w10      = ctrl[stpc_pkg::CTRL_W10_BIT];
    wire        loop_en  = ctrl[stpc_pkg::CTRL_LOOP_BIT];
    wire        is_prbs  = (mode_raw >= 3'h1) && (mode_raw <= 3'h4);
    wire        sel_ctrl = reg_wr && (reg_addr == stpc_pkg::REG_CTRL);
    wire        sel_en   = reg_wr && (reg_addr == stpc_pkg::REG_IRQ_EN);
    wire        sel_clr  = reg_wr && (reg_addr == stpc_pkg::REG_IRQ_CLR);

    // =========================================================
    // phase compensation fifo
    logic [stpc_pkg::FIFO_W-1:0] fifo_mem [stpc_pkg::FIFO_DEPTH];
    logic [stpc_pkg::FIFO_AW:0]  wptr;
    logic [stpc_pkg::FIFO_AW:0]  rptr;
    wire  fifo_empty = (wptr == rptr);
    wire  fifo_full  = (wptr[1:0] == rptr[1:0]) && (wptr[2] != rptr[2]);
    wire  do_wr      = tx_wr && !fifo_full;
    wire  do_rd      = !fifo_empty;
    wire  [stpc_pkg::FIFO_W-1:0] fifo_in  = {tx_ctrl, tx_force_disp, tx_disp_val, tx_data}; // RL11 RL12
    wire  [stpc_pkg::FIFO_W-1:0] fifo_out = fifo_mem[rptr[1:0]];

    // write side runs on clk; one-domain build of the optional write clock
    always_ff @(posedge clk) begin // RL9 RL7
        if (do_wr) begin
            fifo_mem[wptr[1:0]] <= fifo_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || tx_rst) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (do_wr) begin
                wptr <= wptr + 3'h1;
            end
            if (do_rd) begin
                rptr <= rptr + 3'h1;
            end
        end
    end

    wire next_fifo_err = (wptr + (do_wr ? 3'h1 : 3'h0) == rptr + (do_rd ? 3'h1 : 3'h0))
                       || (((wptr + (do_wr ? 3'h1 : 3'h0)) ^ (rptr + (do_rd ? 3'h1 : 3'h0))) == 3'h4);

    // encoder controls leave the fifo together with their byte
    always_ff @(posedge clk) begin
        if (rst || tx_rst) begin
            enc_valid <= 1'b0;
            enc_byte  <= 8'h00;
            enc_k     <= 1'b0;
            enc_force <= 1'b0;
            enc_neg   <= 1'b0;
            fifo_err  <= 1'b1;
        end else begin
            enc_valid <= do_rd;
            if (do_rd) begin
                enc_byte  <= fifo_out[7:0];
                enc_k     <= fifo_out[10];     // RL11
                enc_force <= fifo_out[9];      // RL12
                enc_neg   <= fifo_out[9] && fifo_out[8]; // RL13
            end
            fifo_err <= next_fifo_err;         // RL10
        end
    end

    // =========================================================
    // asynchronous control inputs
    logic       inv_s1;
    logic       inv_s2;
    logic       idle_s1;
    logic       idle_s2;
    logic [3:0] slip_s1;
    logic [3:0] slip_s2;
    always_ff @(posedge clk) begin
        inv_s1  <= tx_invert;
        inv_s2  <= inv_s1;
        idle_s1 <= force_line_idle;
        idle_s2 <= idle_s1;
        slip_s1 <= tx_slip_amount;
        slip_s2 <= slip_s1;
    end

    // =========================================================
    // pattern generator
    function automatic logic fb(input logic [22:0] s, input logic [2:0] m);
        case (m)
            3'h1:    fb = s[6] ^ s[5];
            3'h2:    fb = s[7] ^ s[6];
            3'h3:    fb = s[9] ^ s[6];
            3'h4:    fb = s[22] ^ s[17];
            default: fb = 1'b0;
        endcase
    endfunction

    logic [22:0] gen_state;
    logic [22:0] next_gen_state;
    logic [9:0]  gen_word;
    always_comb begin // RL1 RL17
        next_gen_state = gen_state;
        gen_word       = 10'h000;
        for (int i = 0; i < 10; i++) begin
            if (i < (w10 ? 10 : 8)) begin
                gen_word       = {gen_word[8:0], fb(next_gen_state, mode_raw)};
                next_gen_state = {next_gen_state[21:0], fb(next_gen_state, mode_raw)};
            end
        end
        if (mode_raw == stpc_pkg::PM_HF) begin
            gen_word = w10 ? stpc_pkg::HF_WORD : {2'b00, stpc_pkg::HF_WORD[7:0]};
        end else if (mode_raw == stpc_pkg::PM_LF) begin
            gen_word = stpc_pkg::LF_WORD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || tx_rst || !is_prbs) begin // RL6
            gen_state <= '1;
        end else begin
            gen_state <= next_gen_state;
        end
    end

    // =========================================================
    // polarity, slip and serializer word
    wire  [9:0] wmask   = w10 ? 10'h3FF : 10'h0FF;
    wire  [9:0] tx_src  = (mode_raw == stpc_pkg::PM_OFF) ? enc_word : gen_word; // RL18
    wire  [9:0] tx_pol  = (tx_src ^ (inv_s2 ? 10'h3FF : 10'h000)) & wmask;     // RL14
    logic [9:0] prev_word;
    wire  [19:0] slip_cat = {prev_word, tx_pol};
    wire  [3:0]  slip_amt = (slip_s2 > 4'h9) ? 4'h9 : slip_s2;
    wire  [9:0]  next_ser = 10'((slip_cat >> slip_amt)) & wmask;               // RL15

    always_ff @(posedge clk) begin
        if (rst || tx_rst) begin
            prev_word <= 10'h000;
            ser_word  <= 10'h000;
            ser_idle  <= 1'b0;
            tx_if_clk <= 1'b0;
        end else begin
            prev_word <= tx_pol;
            ser_word  <= idle_s2 ? 10'h000 : next_ser;
            ser_idle  <= idle_s2;              // RL16
            tx_if_clk <= ~tx_if_clk;           // RL8
        end
    end

    // =========================================================
    // pattern verifier
    wire  [9:0] chk_in = loop_en ? gen_word : rx_word; // RL3
    logic [22:0] chk_state;
    logic [22:0] next_chk_state;
    logic        bad;
    always_comb begin
        next_chk_state = chk_state;
        bad            = 1'b0;
        for (int i = 0; i < 10; i++) begin
            if (i < (w10 ? 10 : 8)) begin
                bad = bad | (fb(next_chk_state, mode_raw) != chk_in[(w10 ? 9 : 7) - i]);
                next_chk_state = {next_chk_state[21:0], chk_in[(w10 ? 9 : 7) - i]};
            end
        end
    end

    logic [23:0] bit_cnt;
    logic [1:0]  err_hold;
    wire  [23:0] period = (mode_raw == stpc_pkg::PM_P7)  ? stpc_pkg::PER_P7  :
                          (mode_raw == stpc_pkg::PM_P8)  ? stpc_pkg::PER_P8  :
                          (mode_raw == stpc_pkg::PM_P10) ? stpc_pkg::PER_P10 : stpc_pkg::PER_P23;
    wire  [23:0] step   = w10 ? 24'h00_000A : 24'h00_0008;
    wire         primed = bit_cnt >= 24'(stpc_pkg::LFSR_W);
    wire         mism   = primed && bad;
    wire         cycle  = (bit_cnt + step) >= period;
    wire         active = is_prbs && rx_aligned; // RL2 RL18

    always_ff @(posedge clk) begin
        if (rst || rx_rst || !is_prbs) begin // RL6 RL2
            chk_state <= '0;
            bit_cnt   <= 24'h00_0000;
            chk_done  <= 1'b0;
            chk_err   <= 1'b0;
            err_hold  <= 2'h0;
        end else if (active) begin
            chk_state <= next_chk_state;
            if (mism || cycle) begin
                bit_cnt <= (mism ? 24'(stpc_pkg::LFSR_W) : 24'h00_0000);
            end else begin
                bit_cnt <= bit_cnt + step;
            end
            if (cycle && !mism) begin
                chk_done <= 1'b1;              // RL4
            end
            if (chk_done && mism) begin
                chk_err  <= 1'b1;              // RL5
                err_hold <= 2'(stpc_pkg::ERR_MIN - 1);
            end else if (err_hold != 2'h0) begin
                err_hold <= err_hold - 2'h1;
            end else if (cycle) begin
                chk_err  <= 1'b0;              // RL5
            end
        end else if (err_hold != 2'h0) begin
            err_hold <= err_hold - 2'h1;
        end
    end

    // =========================================================
    // interrupts and register reads
    logic done_d;
    logic err_d;
    wire [IRQ_N-1:0] irq_evt = {fifo_empty && enc_valid, tx_wr && fifo_full,
                                chk_err && !err_d, chk_done && !done_d};
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl     <= stpc_pkg::CTRL_RESET;
            irq_en   <= '0;
            irq_stat <= '0;
            irq      <= 1'b0;
            done_d   <= 1'b0;
            err_d    <= 1'b0;
        end else begin
            if (sel_ctrl) begin
                ctrl <= reg_wdata[4:0];
            end
            if (sel_en) begin
                irq_en <= reg_wdata[IRQ_N-1:0];
            end
            irq_stat <= irq_evt | (irq_stat & ~(sel_clr ? reg_wdata[IRQ_N-1:0] : '0));
            irq      <= |(irq_stat & irq_en);
            done_d   <= chk_done;
            err_d    <= chk_err;
        end
    end

    wire [31:0] rd_mux = (reg_addr == stpc_pkg::REG_CTRL)     ? {27'h0, ctrl} :
                         (reg_addr == stpc_pkg::REG_STATUS)   ? {27'h0, fifo_err, fifo_full,
                                                                 fifo_empty, chk_err, chk_done} :
                         (reg_addr == stpc_pkg::REG_IRQ_STAT) ? {28'h0, irq_stat} :
                         (reg_addr == stpc_pkg::REG_IRQ_EN)   ? {28'h0, irq_en} : 32'h0000_0000;
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // =========================================================
    // checks
    AST_FIFO_ERR: assert property (@(posedge clk) disable iff (rst || tx_rst) // RL10
        (fifo_full || fifo_empty) |-> ##1 fifo_err || $past(do_wr) || $past(do_rd))
        else $error("fifo error not raised");
    AST_KSEL: assert property (@(posedge clk) disable iff (rst || tx_rst) // RL11
        do_rd |=> enc_k == $past(fifo_out[10]))
        else $error("control select lost");
    AST_DISP: assert property (@(posedge clk) disable iff (rst || tx_rst) // RL13
        enc_neg |-> enc_force)
        else $error("negative disparity without forcing");
    AST_INV: assert property (@(posedge clk) disable iff (rst || tx_rst) // RL14
        (!idle_s2 && slip_s2 == 4'h0) |=> ser_word == $past(tx_pol))
        else $error("serializer word mismatch");
    AST_IDLE: assert property (@(posedge clk) disable iff (rst || tx_rst) // RL16
        idle_s2 |=> ser_idle && ser_word == 10'h000)
        else $error("idle not applied");
    AST_DONE_HOLD: assert property (@(posedge clk) disable iff (rst || rx_rst || !is_prbs) // RL4
        chk_done |=> chk_done)
        else $error("done dropped without reset");
    AST_ERR_MIN: assert property (@(posedge clk) disable iff (rst || rx_rst || !is_prbs) // RL5
        $rose(chk_err) |-> chk_err [*3])
        else $error("error flag shorter than three cycles");
    AST_NO_FIXED: assert property (@(posedge clk) disable iff (rst) // RL2
        (mode_raw >= 3'h5) |=> !chk_done && !chk_err)
        else $error("fixed pattern verified");
    AST_RXRST: assert property (@(posedge clk) // RL6
        (rx_rst && !rst) |=> !chk_done && !chk_err)
        else $error("rx reset ignored");
    COV_DONE: cover property (@(posedge clk) disable iff (rst) $rose(chk_done));
    COV_ERR: cover property (@(posedge clk) disable iff (rst) $rose(chk_err));
    COV_FULL: cover property (@(posedge clk) disable iff (rst) fifo_full && tx_wr);
    COV_LOOP: cover property (@(posedge clk) disable iff (rst) loop_en && chk_done);
endmodule

// >>> test/stpc_fabric_model.sv
// fabric partner: drives the transmit side, stands in for the encoder, loops words back
`timescale 1ns/100ps
module stpc_fabric_model (
    // clock
    input  wire logic       clk,
    // encoder request
    input  wire logic       enc_valid,
    input  wire logic [7:0] enc_byte,
    input  wire logic       enc_k,
    input  wire logic       enc_neg,
    // serial side
    input  wire logic [9:0] ser_word,
    // fabric drive
    output logic            tx_wr,
    output logic [7:0]      tx_data,
    output logic            tx_ctrl,
    output logic            tx_force_disp,
    output logic            tx_disp_val,
    output logic            tx_invert,
    output logic [3:0]      tx_slip_amount,
    output logic            force_line_idle,
    output logic [9:0]      enc_word,
    output logic [9:0]      rx_word,
    output logic            rx_aligned
);
    logic [9:0] err_mask;
    initial begin
        {tx_wr, tx_data, tx_ctrl, tx_force_disp, tx_disp_val} = 12'h000;
        {tx_invert, tx_slip_amount, force_line_idle} = 6'h00;
        enc_word = 10'h000;
        rx_word = 10'h000;
        rx_aligned = 1'h0;
        err_mask = 10'h000;
    end
    // encoder stand-in and external loop with optional corruption
    always @(posedge clk) begin
        if (enc_valid === 1'h1)
            enc_word <= {enc_k, enc_neg, enc_byte};
        rx_word <= ser_word ^ err_mask;
    end
    task automatic send(input logic [7:0] d, input logic k, input logic f, input logic v, input logic last);
        tx_wr <= 1'h1;
        tx_data <= d;
        tx_ctrl <= k;
        tx_force_disp <= f;
        tx_disp_val <= v;
        @(posedge clk);
        if (last) begin
            tx_wr <= 1'h0;
            tx_data <= ~d;
        end
    endtask
    // levels are held for many cycles by every caller
    task automatic set_line(input logic inv, input logic [3:0] slip, input logic idle);
        tx_invert <= inv;
        tx_slip_amount <= (slip > 4'h9) ? 4'h9 : slip;
        force_line_idle <= idle;
    endtask
    task automatic set_rx(input logic [9:0] mask, input logic al);
        err_mask <= mask;
        rx_aligned <= al;
    endtask
endmodule

// >>> test/tb_top.sv
// self-checking bench of the transmit coding and pattern test block
`timescale 1ns/100ps
module tb_top;
    logic        clk, rst, tx_rst, rx_rst, reg_wr, reg_rd, rd_d, irq, tx_if_clk, fifo_err;
    logic [7:0]  reg_addr, enc_byte, tx_data;
    logic [31:0] reg_wdata, reg_rdata;
    logic        tx_wr, tx_ctrl, tx_force_disp, tx_disp_val, tx_invert, force_line_idle;
    logic [3:0]  tx_slip_amount;
    logic        enc_valid, enc_k, enc_force, enc_neg, ser_idle, rx_aligned, chk_done, chk_err;
    logic [9:0]  enc_word, ser_word, rx_word, w;
    logic [19:0] sl;
    logic [10:0] enc_q[$];
    logic [63:0] rd_q[$];
    logic [63:0] re;
    int          failures, check_count, cyc, seed;
    stpc_pkg::stpc_mode_t modes[5];

    stpc_top DUT (.clk(clk), .rst(rst), .tx_rst(tx_rst), .rx_rst(rx_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .tx_wr(tx_wr), .tx_data(tx_data), .tx_ctrl(tx_ctrl), .tx_force_disp(tx_force_disp),
        .tx_disp_val(tx_disp_val), .tx_invert(tx_invert), .tx_slip_amount(tx_slip_amount),
        .force_line_idle(force_line_idle), .tx_if_clk(tx_if_clk), .fifo_err(fifo_err),
        .enc_valid(enc_valid), .enc_byte(enc_byte), .enc_k(enc_k), .enc_force(enc_force),
        .enc_neg(enc_neg), .enc_word(enc_word), .ser_word(ser_word), .ser_idle(ser_idle),
        .rx_word(rx_word), .rx_aligned(rx_aligned), .chk_done(chk_done), .chk_err(chk_err));
    stpc_fabric_model fab (.clk(clk), .enc_valid(enc_valid), .enc_byte(enc_byte), .enc_k(enc_k),
        .enc_neg(enc_neg), .ser_word(ser_word), .tx_wr(tx_wr), .tx_data(tx_data), .tx_ctrl(tx_ctrl),
        .tx_force_disp(tx_force_disp), .tx_disp_val(tx_disp_val), .tx_invert(tx_invert),
        .tx_slip_amount(tx_slip_amount), .force_line_idle(force_line_idle), .enc_word(enc_word),
        .rx_word(rx_word), .rx_aligned(rx_aligned));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // monitors: oldest note against each result
    always @(posedge clk) begin
        rd_d <= reg_rd;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
        if (rd_d === 1'h1) begin
            re = (rd_q.size() > 0) ? rd_q.pop_front() : 64'hFFFF_FFFF_DEAD_BEEF;
            check("reg_rdata", re[31:0], reg_rdata & re[63:32]);
        end
        if (enc_valid === 1'h1)
            check("enc fields", (enc_q.size() > 0) ? {21'h0, enc_q.pop_front()} : 32'hFFFF_FFFF,
                {21'h0, enc_byte, enc_k, enc_force, enc_neg});
    end
    // ==========================================
    // bus and control tasks
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        reg_wdata <= ~d;
        @(posedge clk);
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'h1;
        rd_q.push_back({m, e & m});
        @(posedge clk);
        reg_rd <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic set_ctrl(input logic [2:0] m, input logic w10, input logic lp);
        reg_write(stpc_pkg::REG_CTRL, {27'h0, lp, w10, m});
    endtask
    task automatic pulse(input bit rx);
        if (rx)
            rx_rst <= 1'h1;
        else
            tx_rst <= 1'h1;
        @(posedge clk);
        rx_rst <= 1'h0;
        tx_rst <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_level(ref logic s, input logic lvl, input int lim);
        for (int n = 0; n < lim && s !== lvl; n++)
            @(posedge clk);
        @(negedge clk);
    endtask
    // ==========================================
    // main sequence
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst, tx_rst, rx_rst, reg_wr, reg_rd, rd_d} = 6'h20;
        {reg_addr, reg_wdata} = 40'h0;
        {failures, check_count, cyc} = '0;
        seed = 32'h1fe6;
        modes = '{stpc_pkg::PM_P7, stpc_pkg::PM_P8, stpc_pkg::PM_P10, stpc_pkg::PM_HF, stpc_pkg::PM_LF};
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        reg_read(stpc_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        reg_read(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        reg_read(stpc_pkg::REG_IRQ_CLR, 32'hFFFF_FFFF, 32'h0000_0000);
        set_ctrl(3'h0, 1'h1, 1'h0);
        reg_read(stpc_pkg::REG_CTRL, 32'h0000_001F, 32'h0000_0008);
        @(negedge clk);
        check("fifo_err idle", 1, fifo_err);
        w = {9'h0, tx_if_clk};
        @(negedge clk);
        check("tx_if_clk", {31'h0, ~w[0]}, tx_if_clk);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            w[7:0] = 8'($random(seed));
            enc_q.push_back({w[7:0], i[2], i[1], i[1] & i[0]});
            fab.send(w[7:0], i[2], i[1], i[0], i == 7);
        end
        w = {2'h3, w[7:0]};
        repeat (6) @(posedge clk);
        check("enc drained", 0, enc_q.size());
        for (int s = 0; s < 10; s++) begin
            fab.set_line(s[0], s[3:0], 1'h0);
            repeat (8) @(posedge clk);
            @(negedge clk);
            sl = {w, w} >> s;
            check("ser_word slip", {22'h0, sl[9:0] ^ {10{s[0]}}}, ser_word);
        end
        fab.set_line(1'h0, 4'h0, 1'h1);
        repeat (8) @(posedge clk);
        @(negedge clk);
        check("idle line", 32'h0000_0400, {ser_idle, ser_word});
        fab.set_line(1'h0, 4'h0, 1'h0);
        pulse(1'b0);
        @(negedge clk);
        check("tx reset", 32'h0000_0100, {fifo_err, enc_byte});
        $display("test transmit path done");
        fab.set_rx(10'h3FF, 1'h1);
        for (int i = 0; i < 5; i++) begin
            set_ctrl(modes[i], i > 1, 1'h1);
            pulse(1'b1);
            repeat (i > 2 ? 300 : 0) @(posedge clk);
            if (i < 3)
                wait_level(chk_done, 1'h1, 600);
            check("loop status", {31'h0, i < 3}, {chk_err, chk_done});
            if (i == 0)
                check("upper bits", 0, ser_word[9:8]);
            if (i > 2)
                check("fixed word", i == 3 ? stpc_pkg::HF_WORD : stpc_pkg::LF_WORD, ser_word);
            if (i == 2) begin
                reg_write(stpc_pkg::REG_IRQ_EN, 32'h0000_0001);
                reg_read(stpc_pkg::REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
                check("irq done", 1, irq);
                reg_write(stpc_pkg::REG_IRQ_CLR, 32'h0000_0001);
                repeat (2) @(posedge clk);
                check("irq cleared", 0, irq);
            end
        end
        $display("test pattern loopback done");
        fab.set_rx(10'h000, 1'h1);
        reg_write(stpc_pkg::REG_IRQ_EN, 32'h0000_0002);
        set_ctrl(stpc_pkg::PM_P7, 1'h0, 1'h0);
        pulse(1'b1);
        wait_level(chk_done, 1'h1, 600);
        fab.set_rx(10'h001, 1'h1);
        @(posedge clk);
        fab.set_rx(10'h000, 1'h1);
        wait_level(chk_err, 1'h1, 60);
        for (int i = 0; i < 3; i++) begin
            check("err held", 3, {chk_err, chk_done});
            @(negedge clk);
        end
        check("irq err", 1, irq);
        wait_level(chk_err, 1'h0, 800);
        check("err cleared", 1, {chk_err, chk_done});
        pulse(1'b1);
        @(negedge clk);
        check("rx reset", 0, {chk_err, chk_done});
        $display("test error flag done");
        tally_and_finish();
    end
endmodule
